/* rtl/agu_pkg.sv */
package agu_pkg;
  // Register byte offsets (printed offsets not all multiples of four: indices)
  localparam logic [7:0] IDX_BITREV = 8'h20;
  localparam logic [7:0] IDX_MODCTL = 8'h46;
  localparam logic [7:0] IDX_XSTART = 8'h48;
  localparam logic [7:0] IDX_XEND = 8'h4a;
  localparam logic [7:0] IDX_YSTART = 8'h4c;
  localparam logic [7:0] IDX_YEND = 8'h4e;
  localparam logic [7:0] IDX_DISCNT = 8'h52;
  localparam int ADDR_SHIFT = 2;
  // Field layout of the circular/bit-reverse control register
  localparam int MC_XEN = 15;
  localparam int MC_YEN = 14;
  localparam int MC_BWM_LO = 8;
  localparam int MC_YWM_LO = 4;
  localparam int MC_XWM_LO = 0;
  localparam int BR_EN = 15;
  localparam logic [3:0] PTR_NONE = 4'hf;
  localparam logic [15:0] MODCTL_RST = 16'h0000;
  localparam logic [15:0] DISCNT_RST = 16'h0000;
  localparam logic [15:0] BITREV_RST = 16'h0000;
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [15:0] END_RST = 16'h0001;
  localparam logic [15:0] DISCNT_MASK = 16'h3fff;
  localparam logic [15:0] NEAR_MASK = 16'h1fff;
  localparam logic [15:0] WORD_MASK = 16'hfffe;
  localparam logic [15:0] ODD_BIT = 16'h0001;

  typedef enum logic [2:0] {
    AM_FILE = 3'b000,
    AM_REG = 3'b001,
    AM_IND = 3'b010,
    AM_POST = 3'b011,
    AM_PRE = 3'b100,
    AM_ROFS = 3'b101,
    AM_LOFS = 3'b110,
    AM_LIT = 3'b111
  } agu_mode_t;

  typedef enum logic [1:0] {
    DST_FILE = 2'b00,
    DST_DEFAULT_WORKING_REGISTER = 2'b01,
    DST_MEM = 2'b10,
    DST_PAIR = 2'b11
  } agu_dst_t;

  // Request from the instruction decoder
  typedef struct packed {
    logic valid;
    logic y_space;
    logic is_mac;
    logic is_move;
    logic lit10;
    agu_mode_t mode;
    logic [3:0] ptr_sel;
    logic [3:0] ofs_sel;
    logic [3:0] op1_sel;
    logic [15:0] imm;
    logic [15:0] modifier;
    agu_dst_t dst;
  } agu_req_t;

  // Result towards data memory and register file
  typedef struct packed {
    logic valid;
    logic mem_access;
    logic [15:0] addr;
    logic [15:0] operand2;
    logic [15:0] operand1;
    logic wb_en;
    logic [3:0] wb_sel;
    logic [15:0] wb_value;
    logic circ_active;
    logic brev_active;
    agu_dst_t dst;
    logic [3:0] dst_reg;
  } agu_res_t;
endpackage : agu_pkg

/* rtl/agu_top.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
// Behaviour
// - Separate X and Y generators compute addresses independently.
// - Y generator only serves word reads of multiply-accumulate instructions.
// - Circular on data and program space; bit-reverse on data only.
// - File-register direct address from 13-bit field, near 8192 bytes.
// - Register direct uses working register contents, no memory address.
// - Register indirect uses pointer value unchanged as address.
// - Post-modified uses pointer, then pointer changes by constant.
// - Pre-modified adds signed constant first, result is the address.
// - Register offset address is pointer plus offset working register.
// - Literal offset address is pointer plus instruction literal.
// - File-register instructions use working register zero implicitly.
// - Result goes to file register or default register; multiply to pair.
// - Move instruction reaches the whole data space.
// - Three-operand first operand is always a working register.
// - Second operand is register, memory, or 5-bit literal.
// - Result goes to working register or memory location.
// - Arithmetic modes include direct, indirect, pre, post, 5/10-bit literals.
// - X circular only when select not 15 and X enable set.
// - Y circular only when select not 15 and Y enable set.
// - Bit-reverse needs select not 15, enable set, pre/post increment.
module agu_top
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoder request and working register file
  input wire agu_req_t req,
  input wire logic [15:0] default_working_register_file [16],
  // Data memory read data for operand 2
  input wire logic [15:0] mem_rdata,
  // Generated result
  output agu_res_t res
);

  logic [15:0] modctl_reg;
  logic [15:0] bitrev_reg;
  logic [15:0] xstart_reg;
  logic [15:0] xend_reg;
  logic [15:0] ystart_reg;
  logic [15:0] yend_reg;
  logic [15:0] discnt_reg;
  agu_res_t res_next;

  // APB decode
  logic wr_en;
  logic rd_hit;
  logic [9:0] widx;
  assign pready = 1'b1;
  assign widx = paddr[11:ADDR_SHIFT];
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    case (widx[7:0])
      IDX_BITREV: prdata = {16'h0000, bitrev_reg};
      IDX_MODCTL: prdata = {16'h0000, modctl_reg};
      IDX_XSTART: prdata = {16'h0000, xstart_reg};
      IDX_XEND: prdata = {16'h0000, xend_reg};
      IDX_YSTART: prdata = {16'h0000, ystart_reg};
      IDX_YEND: prdata = {16'h0000, yend_reg};
      IDX_DISCNT: prdata = {16'h0000, discnt_reg};
      default: begin
        prdata = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    if (widx[9:8] != 2'b00) begin
      prdata = 32'h0000_0000;
      rd_hit = 1'b0;
    end
  end
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modctl_reg <= MODCTL_RST;
      bitrev_reg <= BITREV_RST;
      xstart_reg <= START_RST;
      xend_reg <= END_RST;
      ystart_reg <= START_RST;
      yend_reg <= END_RST;
      discnt_reg <= DISCNT_RST;
    end else if (wr_en && rd_hit) begin
      case (widx[7:0])
        IDX_BITREV: bitrev_reg <= pwdata[15:0];
        IDX_MODCTL: modctl_reg <= pwdata[15:0];
        // Start forced even, end forced odd
        IDX_XSTART: xstart_reg <= pwdata[15:0] & WORD_MASK;
        IDX_XEND: xend_reg <= pwdata[15:0] | ODD_BIT;
        IDX_YSTART: ystart_reg <= pwdata[15:0] & WORD_MASK;
        IDX_YEND: yend_reg <= pwdata[15:0] | ODD_BIT;
        IDX_DISCNT: discnt_reg <= pwdata[15:0] & DISCNT_MASK;
        default: discnt_reg <= discnt_reg;
      endcase
    end
  end

  // Mode enables
  logic x_circ_on;
  logic y_circ_on;
  logic brev_on;
  logic [3:0] x_pointer_select;
  logic [3:0] y_pointer_select;
  logic [3:0] bitrev_pointer_select;
  assign x_pointer_select = modctl_reg[MC_XWM_LO +: 4];
  assign y_pointer_select = modctl_reg[MC_YWM_LO +: 4];
  assign bitrev_pointer_select = modctl_reg[MC_BWM_LO +: 4];
  assign x_circ_on = modctl_reg[MC_XEN] && (x_pointer_select != PTR_NONE);
  assign y_circ_on = modctl_reg[MC_YEN] && (y_pointer_select != PTR_NONE);
  assign brev_on = bitrev_reg[BR_EN] && (bitrev_pointer_select != PTR_NONE);

  // Per-generator address arithmetic: index 0 is X, 1 is Y
  logic [15:0] ptr_val;
  logic [15:0] ofs_val;
  logic [15:0] ea_raw [2];
  logic [15:0] wb_raw [2];
  logic [15:0] ea_fix [2];
  logic [15:0] wb_fix [2];
  logic circ_g [2];
  logic [15:0] lo_b [2];
  logic [15:0] hi_b [2];
  assign ptr_val = default_working_register_file[req.ptr_sel];
  assign ofs_val = default_working_register_file[req.ofs_sel];
  assign lo_b[0] = xstart_reg;
  assign hi_b[0] = xend_reg;
  assign lo_b[1] = ystart_reg;
  assign hi_b[1] = yend_reg;
  assign circ_g[0] = x_circ_on && (req.ptr_sel == x_pointer_select);
  assign circ_g[1] = y_circ_on && (req.ptr_sel == y_pointer_select);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_agu
      always_comb begin
        ea_raw[g] = ptr_val;
        wb_raw[g] = ptr_val;
        case (req.mode)
          AM_IND: ea_raw[g] = ptr_val;
          AM_POST: begin
            ea_raw[g] = ptr_val;
            wb_raw[g] = ptr_val + req.modifier;
          end
          AM_PRE: begin
            ea_raw[g] = ptr_val + req.modifier;
            wb_raw[g] = ptr_val + req.modifier;
          end
          AM_ROFS: ea_raw[g] = ptr_val + ofs_val;
          AM_LOFS: ea_raw[g] = ptr_val + req.imm;
          default: ea_raw[g] = ptr_val;
        endcase
      end
      // circular wrap for data and program pointers
      always_comb begin
        ea_fix[g] = ea_raw[g];
        wb_fix[g] = wb_raw[g];
        if (circ_g[g]) begin
          if (ea_raw[g] > hi_b[g]) begin
            ea_fix[g] = ea_raw[g] - (hi_b[g] - lo_b[g] + ODD_BIT);
          end else if (ea_raw[g] < lo_b[g]) begin
            ea_fix[g] = ea_raw[g] + (hi_b[g] - lo_b[g] + ODD_BIT);
          end
          if (wb_raw[g] > hi_b[g]) begin
            wb_fix[g] = wb_raw[g] - (hi_b[g] - lo_b[g] + ODD_BIT);
          end else if (wb_raw[g] < lo_b[g]) begin
            wb_fix[g] = wb_raw[g] + (hi_b[g] - lo_b[g] + ODD_BIT);
          end
        end
      end
    end
  endgenerate

  // Bit-reversed post/pre increment on X data space
  logic use_brev;
  logic [15:0] brev_sum;
  logic [15:0] brev_mod;
  logic [15:0] rev_ptr;
  logic [15:0] rev_mod;
  assign brev_mod = {bitrev_reg[14:0], 1'b0};
  // increment modes only, X data space
  assign use_brev = brev_on && !req.y_space && (req.ptr_sel == bitrev_pointer_select)
                    && ((req.mode == AM_POST) || (req.mode == AM_PRE));
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rev_ptr[i] = ptr_val[15 - i];
      rev_mod[i] = brev_mod[15 - i];
    end
  end
  logic [15:0] rev_sum;
  assign rev_sum = rev_ptr + rev_mod;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      brev_sum[i] = rev_sum[15 - i];
    end
  end

  // Selection and operand sourcing
  logic sel_y;
  // Y only for word reads of multiply-accumulate
  assign sel_y = req.y_space && req.is_mac;

  always_comb begin
    res_next = '0;
    res_next.valid = req.valid;
    res_next.dst = req.dst;
    res_next.operand1 = default_working_register_file[req.op1_sel];
    res_next.dst_reg = req.op1_sel;
    res_next.mem_access = 1'b1;
    res_next.addr = sel_y ? (ea_fix[1] & WORD_MASK) : ea_fix[0];
    res_next.circ_active = sel_y ? circ_g[1] : circ_g[0];
    res_next.operand2 = mem_rdata;
    case (req.mode)
      AM_FILE: begin
        // near space direct address; move reaches all
        res_next.addr = req.is_move ? req.imm : (req.imm & NEAR_MASK);
        res_next.circ_active = 1'b0;
        res_next.operand1 = default_working_register_file[0];
        res_next.dst_reg = 4'h0;
      end
      AM_REG: begin
        res_next.mem_access = 1'b0;
        res_next.addr = 16'h0000;
        res_next.circ_active = 1'b0;
        res_next.operand2 = ptr_val;
      end
      AM_LIT: begin
        res_next.mem_access = 1'b0;
        res_next.addr = 16'h0000;
        res_next.circ_active = 1'b0;
        res_next.operand2 = req.lit10 ? {6'h00, req.imm[9:0]} : {11'h000, req.imm[4:0]};
      end
      default: res_next.mem_access = 1'b1;
    endcase
    if (use_brev && !sel_y) begin
      res_next.brev_active = 1'b1;
      res_next.circ_active = 1'b0;
      res_next.addr = (req.mode == AM_PRE) ? brev_sum : ptr_val;
    end
    if ((req.mode == AM_POST) || (req.mode == AM_PRE)) begin
      res_next.wb_en = req.valid;
      res_next.wb_sel = req.ptr_sel;
      res_next.wb_value = use_brev && !sel_y ? brev_sum : (sel_y ? wb_fix[1] : wb_fix[0]);
    end
    // destination class passes to the register file
    if (req.dst == DST_DEFAULT_WORKING_REGISTER) begin
      res_next.dst_reg = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res <= '0;
    end else begin
      res <= res_next;
    end
  end

  // write-back matches the request one cycle later
  a_post_wb: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.mode == AM_POST && !use_brev && !circ_g[0] && !sel_y)
    |=> (res.wb_en && res.wb_value == $past(ptr_val) + $past(req.modifier)
         && res.addr == $past(ptr_val)))
    else $error("post-modify result wrong");
  a_pre_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (req.valid && req.mode == AM_PRE && !use_brev && !sel_y)
    |=> (res.addr == res.wb_value))
    else $error("pre-modify address differs from pointer");
  a_near_file: assert property (@(posedge pclk) disable iff (!presetn)
    (req.mode == AM_FILE && !req.is_move) |=> (res.addr <= NEAR_MASK))
    else $error("file address outside near space");
  // no memory access in register direct
  a_reg_direct: assert property (@(posedge pclk) disable iff (!presetn)
    (req.mode == AM_REG) |=> (!res.mem_access && res.operand2 == $past(ptr_val)))
    else $error("register direct accessed memory");
  a_x_circ: assert property (@(posedge pclk) disable iff (!presetn)
    ((!modctl_reg[MC_XEN] || x_pointer_select == PTR_NONE) && !sel_y) |=> !res.circ_active)
    else $error("X circular active while disabled");
  a_y_circ: assert property (@(posedge pclk) disable iff (!presetn)
    ((!modctl_reg[MC_YEN] || y_pointer_select == PTR_NONE) && sel_y) |=> !res.circ_active)
    else $error("Y circular active while disabled");
  a_brev_mode: assert property (@(posedge pclk) disable iff (!presetn)
    res.brev_active |-> ($past(req.mode) == AM_POST || $past(req.mode) == AM_PRE))
    else $error("bit-reverse in wrong mode");
  a_rofs_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (req.mode == AM_ROFS && !circ_g[0] && !sel_y)
    |=> (res.addr == $past(ptr_val) + $past(ofs_val) && !res.wb_en))
    else $error("register offset address wrong");
  a_y_word: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_y && req.mode == AM_IND) |=> (res.addr[0] == 1'b0))
    else $error("Y address not word aligned");

endmodule : agu_top

/* testbench/agu_core_model.sv */
`timescale 1ns/100ps
module agu_core_model
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench register preload
  input wire logic load,
  input wire logic [15:0] load_regs [16],
  // Generator result
  input wire agu_res_t res,
  // Register file and memory data
  output logic [15:0] default_working_register_file [16],
  output logic [15:0] mem_rdata
);
  logic [15:0] last_q;
  always_ff @(posedge pclk) begin
    if (load) begin
      default_working_register_file <= load_regs;
    end else if (presetn && res.valid && res.wb_en) begin
      default_working_register_file[res.wb_sel] <= res.wb_value;
    end
  end
  // Idle bus shows inverse of last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 16'h0;
    end else if (res.mem_access) begin
      last_q <= mem_rdata;
    end
  end
  assign mem_rdata = res.mem_access ? (res.addr ^ 16'ha5c3) : ~last_q;
endmodule : agu_core_model

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import agu_pkg::*;
  localparam logic [7:0] IDXS [7] = '{IDX_MODCTL, IDX_BITREV, IDX_XSTART, IDX_XEND,
    IDX_YSTART, IDX_YEND, IDX_DISCNT};
  localparam logic [15:0] RSTS [7] = '{MODCTL_RST, BITREV_RST, START_RST, END_RST,
    START_RST, END_RST, DISCNT_RST};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  agu_req_t req = '0;
  logic [15:0] default_working_register_file [16];
  logic [15:0] mem_rdata;
  agu_res_t res;
  agu_res_t res_pre;
  logic load = 1'b0;
  logic [15:0] w [16];
  logic [31:0] seed = 32'hb7a9bdd8;
  int n_mismatch = 0;
  int compares = 0;

  always #4 pclk = ~pclk;

  agu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .default_working_register_file(default_working_register_file), .mem_rdata(mem_rdata), .res(res));
  agu_core_model u_core (.pclk(pclk), .presetn(presetn), .load(load), .load_regs(w),
    .res(res), .default_working_register_file(default_working_register_file), .mem_rdata(mem_rdata));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [15:0] reg_exp(logic [7:0] idx, logic [15:0] v);
    if (idx == IDX_XSTART || idx == IDX_YSTART) return v & WORD_MASK;
    if (idx == IDX_XEND || idx == IDX_YEND) return v | ODD_BIT;
    if (idx == IDX_DISCNT) return v & DISCNT_MASK;
    return v;
  endfunction : reg_exp

  function automatic logic [15:0] exp_addr(agu_req_t r);
    case (r.mode)
      AM_FILE: return r.is_move ? r.imm : (r.imm & NEAR_MASK);
      AM_PRE: return w[r.ptr_sel] + r.modifier;
      AM_ROFS: return w[r.ptr_sel] + w[r.ofs_sel];
      AM_LOFS: return w[r.ptr_sel] + r.imm;
      default: return w[r.ptr_sel];
    endcase
  endfunction : exp_addr

  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
      output logic [15:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 12'(idx) << ADDR_SHIFT;
    pwdata <= {16'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      n_mismatch++;
      $display("mismatch at %0t: no pready", $time);
      tally_and_finish();
    end
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic op(input agu_req_t r);
    @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    req <= r;
    #1;
    res_pre = res;
    @(posedge pclk);
    req.valid <= 1'b0;
    #1;
  endtask : op

  task automatic corner(input logic [15:0] ctl, input agu_mode_t m, input logic ysp,
      input logic [3:0] p, input logic [15:0] wv, input logic [15:0] ea,
      input logic [15:0] nv, input logic ca, input logic ba);
    agu_req_t r;
    logic [15:0] rd;
    logic err;
    apb(1'b1, IDX_MODCTL, ctl, rd, err);
    r = '0;
    r.valid = 1'b1;
    r.mode = m;
    r.y_space = ysp;
    r.is_mac = ysp;
    r.ptr_sel = p;
    r.modifier = 16'h0002;
    w[p] = wv;
    op(r);
    chk(16'(res.circ_active), 16'(ca), "circular flag");
    chk(16'(res.brev_active), 16'(ba), "bit-reverse flag");
    if (!ba) begin
      chk(res.addr, ea, "wrapped address");
      if (m == AM_POST || m == AM_PRE) begin
        chk(res.wb_value, nv, "wrapped pointer");
        @(posedge pclk);
        #1;
        chk(default_working_register_file[p], nv, "pointer written back");
      end
    end
  endtask : corner

  initial begin
    logic [15:0] rd;
    logic err;
    agu_req_t r;
    logic [31:0] v;
    logic [15:0] ed;
    foreach (w[i]) w[i] = 16'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, IDXS[i], 16'h0, rd, err);
      chk(rd, RSTS[i], "reset value");
    end
    for (int i = 0; i < 7; i++) begin
      v = rnd();
      apb(1'b1, IDXS[i], v[15:0], rd, err);
      apb(1'b0, IDXS[i], 16'h0, rd, err);
      chk(rd, reg_exp(IDXS[i], v[15:0]), "read back");
      chk(16'(err), 16'h0, "mapped error");
    end
    apb(1'b1, 8'h30, 16'hffff, rd, err);
    chk(16'(err), 16'h1, "unmapped write");
    apb(1'b0, 8'h30, 16'h0, rd, err);
    chk(rd, 16'h0, "unmapped read");
    apb(1'b1, IDX_XSTART, 16'h1001, rd, err);
    apb(1'b1, IDX_XEND, 16'h100e, rd, err);
    apb(1'b1, IDX_YSTART, 16'h2000, rd, err);
    apb(1'b1, IDX_YEND, 16'h200e, rd, err);
    apb(1'b1, IDX_BITREV, 16'h8008, rd, err);
    corner(16'h8ff3, AM_POST, 1'b0, 4'h3, 16'h100e, 16'h100e, 16'h1000, 1'b1, 1'b0);
    corner(16'h8ff3, AM_PRE, 1'b0, 4'h3, 16'h100e, 16'h1000, 16'h1000, 1'b1, 1'b0);
    corner(16'h8fff, AM_POST, 1'b0, 4'h3, 16'h100e, 16'h100e, 16'h1010, 1'b0, 1'b0);
    corner(16'h4f3f, AM_POST, 1'b1, 4'h3, 16'h200e, 16'h200e, 16'h2000, 1'b1, 1'b0);
    corner(16'h4f3f, AM_IND, 1'b1, 4'h3, 16'h2003, 16'h2002, 16'h0, 1'b1, 1'b0);
    corner(16'h05ff, AM_PRE, 1'b0, 4'h5, 16'h0100, 16'h0, 16'h0, 1'b0, 1'b1);
    corner(16'h05ff, AM_IND, 1'b0, 4'h5, 16'h0100, 16'h0100, 16'h0, 1'b0, 1'b0);
    corner(16'h0fff, AM_PRE, 1'b0, 4'h5, 16'h0100, 16'h0102, 16'h0102, 1'b0, 1'b0);
    apb(1'b1, IDX_BITREV, 16'h0, rd, err);
    for (int n = 0; n < 160; n++) begin
      r = '0;
      v = rnd();
      r.valid = 1'b1;
      r.mode = agu_mode_t'(v[2:0]);
      r.is_move = v[3];
      r.lit10 = v[4];
      r.dst = agu_dst_t'(v[6:5]);
      r.ptr_sel = v[11:8];
      r.ofs_sel = v[15:12];
      r.op1_sel = v[19:16];
      v = rnd();
      r.imm = v[15:0];
      r.modifier = v[31:16];
      foreach (w[i]) w[i] = 16'(rnd() >> 8);
      op(r);
      chk(16'(res.valid), 16'h1, "valid");
      if (r.mode != AM_REG && r.mode != AM_LIT)
        chk(res.addr, exp_addr(r), "address");
      if (r.mode == AM_REG) chk(res.operand2, w[r.ptr_sel], "direct operand");
      chk(16'(res.mem_access), 16'(r.mode != AM_REG && r.mode != AM_LIT), "memory access");
      if (r.mode != AM_REG && r.mode != AM_LIT && res_pre.mem_access)
        chk(res.operand2, res_pre.addr ^ 16'ha5c3, "memory operand");
      chk(16'(res.dst), 16'(r.dst), "dest class");
      if (r.mode == AM_POST || r.mode == AM_PRE)
        chk(16'(res.wb_sel), 16'(r.ptr_sel), "write-back register");
      if (r.mode == AM_LIT)
        chk(res.operand2, r.imm & (r.lit10 ? 16'h03ff : 16'h001f), "literal");
      if (r.mode == AM_POST || r.mode == AM_PRE)
        chk(res.wb_value, w[r.ptr_sel] + r.modifier, "modified pointer");
      chk(16'(res.wb_en), 16'(r.mode == AM_POST || r.mode == AM_PRE), "write-back");
      if (r.mode == AM_FILE) chk(res.operand1, w[0], "implied register");
      else chk(res.operand1, w[r.op1_sel], "first operand");
      ed = (r.dst == DST_DEFAULT_WORKING_REGISTER || r.mode == AM_FILE) ? 16'h0 : 16'(r.op1_sel);
      chk(16'(res.dst_reg), ed, "dest");
    end
    tally_and_finish();
  end
endmodule : testbench
